// ===== hw/exc_seq_pkg.sv
// Constants for the exception recognition sequencer.
// Assumes a single core clock and an AXI4-Lite register slave.
// ----------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------
`default_nettype none

package exc_seq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS      = 8'h00;
  localparam logic [7:0] OFS_SAVED       = 8'h04;
  localparam logic [7:0] OFS_VBASE       = 8'h08;
  localparam logic [7:0] OFS_SCORE       = 8'h0c;
  localparam logic [7:0] OFS_SHADOW_SB   = 8'h10;
  localparam logic [7:0] OFS_FETCH_PTR   = 8'h14;
  localparam logic [7:0] OFS_SH_EXEC     = 8'h18;
  localparam logic [7:0] OFS_SH_NEXT     = 8'h1c;
  localparam logic [7:0] OFS_SH_FETCH    = 8'h20;
  localparam logic [7:0] OFS_XACT_STAT   = 8'h24;
  localparam logic [7:0] OFS_FAULT_ADDR  = 8'h28;
  localparam logic [7:0] OFS_FAULT_VAL   = 8'h2c;
  localparam logic [7:0] OFS_FLOAT_CTRL  = 8'h30;
  localparam logic [7:0] OFS_FLOAT_STAT  = 8'h34;
  localparam logic [7:0] OFS_SEQ_STATE   = 8'h38;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int SHADOW_FREEZE_BIT = 0;
  localparam int INT_DISABLE_BIT   = 1;
  localparam int FLOAT_DISABLE_BIT = 3;
  localparam int SUPERVISOR_BIT    = 31;
  localparam logic [31:0] ENTRY_SET_MASK  = 32'h8000_000b;
  localparam logic [31:0] STATUS_ONE_MASK = 32'h0000_03f0;
  localparam logic [31:0] STATUS_RESET    = 32'h8000_03f0;
  localparam logic [31:0] VBASE_MASK      = 32'hffff_f000;
  localparam int VEC_NUM_W  = 9;
  localparam logic [8:0] FATAL_VECTOR = 9'h00a;
  localparam int XACT_VALID_BIT = 0;
  localparam int PTR_VALID_BIT  = 1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DRAIN  = 3'b001,
    ST_SAVE   = 3'b010,
    ST_SWITCH = 3'b011,
    ST_VECTOR = 3'b100
  } seq_state_t;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : exc_seq_pkg

`default_nettype wire

// ===== hw/axil_slave_port.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the register file answers reads combinationally.
`default_nettype none

module axil_slave_port
  import exc_seq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_req,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);

  logic aw_have_q;
  logic w_have_q;

  assign s_awready = !aw_have_q && !s_bvalid;
  assign s_wready  = !w_have_q && !s_bvalid;
  assign wr_req    = aw_have_q && w_have_q && !s_bvalid;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_have_q <= 1'b1;
        wr_addr   <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_have_q <= 1'b1;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
      end
      if (wr_req)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_arready = !s_rvalid;
  assign rd_addr   = s_araddr;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
      s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
      s_rvalid <= 1'b0;
  end

endmodule : axil_slave_port

`default_nettype wire

// ===== hw/exception_recognition_sequencer.sv
// Exception recognition sequencer: drain, save status, switch state, vector.
// Assumes the pipeline, data unit and float unit share ref_clk.
`default_nettype none

module exception_recognition_sequencer
  import exc_seq_pkg::*;
#(
  parameter int SB_W = 32
)
(
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  // AXI4-Lite registers
  input  wire logic [7:0]      s_awaddr,
  input  wire logic            s_awvalid,
  output logic                 s_awready,
  input  wire logic [31:0]     s_wdata,
  input  wire logic [3:0]      s_wstrb,
  input  wire logic            s_wvalid,
  output logic                 s_wready,
  output logic [1:0]           s_bresp,
  output logic                 s_bvalid,
  input  wire logic            s_bready,
  input  wire logic [7:0]      s_araddr,
  input  wire logic            s_arvalid,
  output logic                 s_arready,
  output logic [31:0]          s_rdata,
  output logic [1:0]           s_rresp,
  output logic                 s_rvalid,
  input  wire logic            s_rready,
  // Exception request from the pipeline
  input  wire logic            exc_req,
  input  wire logic [8:0]      exc_vector,
  input  wire logic            exc_is_data,
  input  wire logic            exc_is_trap,
  input  wire logic            rte_exec,
  // Data unit
  input  wire logic            data_pending,
  input  wire logic            data_fault,
  input  wire logic [31:0]     data_fault_addr,
  input  wire logic [31:0]     data_fault_value,
  input  wire logic            data_fault_store,
  // Pipeline state
  input  wire logic [SB_W-1:0] sb_set,
  input  wire logic [SB_W-1:0] sb_clr,
  input  wire logic [31:0]     cur_exec_ptr,
  input  wire logic [31:0]     cur_next_ptr,
  input  wire logic [31:0]     cur_fetch_ptr,
  input  wire logic            prefetch_resp,
  input  wire logic            prefetch_fault,
  // Float unit
  input  wire logic            fp_wb_req,
  input  wire logic            fp_exc_req,
  // Outputs
  output logic                 exc_busy,
  output logic                 fetch_redirect,
  output logic [31:0]          fetch_addr,
  output logic                 ptr_valid_clear,
  output logic                 prefetch_discard,
  output logic                 code_fault_taken,
  output logic                 fp_wb_en,
  output logic                 fp_exc_sig,
  output logic [SB_W-1:0]      scoreboard_out,
  output logic [31:0]          status_out
);

  seq_state_t        state_q;
  logic [31:0]       status_q;
  logic [31:0]       saved_q;
  logic [31:0]       vbase_q;
  logic [SB_W-1:0]   sb_q;
  logic [SB_W-1:0]   shadow_sb_q;
  logic [31:0]       fetch_ptr_q;
  logic [31:0]       sh_exec_q;
  logic [31:0]       sh_next_q;
  logic [31:0]       sh_fetch_q;
  logic [31:0]       xact_stat_q;
  logic [31:0]       fault_addr_q;
  logic [31:0]       fault_val_q;
  logic [31:0]       float_ctrl_q;
  logic [31:0]       float_stat_q;
  logic [8:0]        vec_q;
  logic              vec_data_q;

  logic              wr_req;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic [7:0]        rd_addr;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic [31:0]       wmask;
  logic              frozen;
  logic              take_exc;

  assign frozen   = status_q[SHADOW_FREEZE_BIT];
  assign take_exc = (state_q == ST_IDLE) && exc_req;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  axil_slave_port u_bus (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_req    (wr_req),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_ok),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  // Byte enables to bit mask
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = {8{wr_strb[i]}};
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  always_comb
  begin
    case (wr_addr)
      OFS_STATUS, OFS_SAVED, OFS_VBASE, OFS_SHADOW_SB, OFS_SH_EXEC, OFS_SH_NEXT,
      OFS_SH_FETCH, OFS_XACT_STAT, OFS_FAULT_ADDR, OFS_FAULT_VAL, OFS_FLOAT_CTRL,
      OFS_FLOAT_STAT: wr_ok = 1'b1;
      default:        wr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_ok = 1'b1;
    case (rd_addr)
      OFS_STATUS:     rd_data = status_q;
      OFS_SAVED:      rd_data = saved_q;
      OFS_VBASE:      rd_data = vbase_q;
      OFS_SCORE:      rd_data = 32'(sb_q);
      OFS_SHADOW_SB:  rd_data = 32'(shadow_sb_q);
      OFS_FETCH_PTR:  rd_data = fetch_ptr_q;
      OFS_SH_EXEC:    rd_data = sh_exec_q;
      OFS_SH_NEXT:    rd_data = sh_next_q;
      OFS_SH_FETCH:   rd_data = sh_fetch_q;
      OFS_XACT_STAT:  rd_data = xact_stat_q;
      OFS_FAULT_ADDR: rd_data = fault_addr_q;
      OFS_FAULT_VAL:  rd_data = fault_val_q;
      OFS_FLOAT_CTRL: rd_data = float_ctrl_q;
      OFS_FLOAT_STAT: rd_data = float_stat_q;
      OFS_SEQ_STATE:  rd_data = {29'h0, state_q};
      default:
      begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_q    <= ST_IDLE;
      vec_q      <= 9'h000;
      vec_data_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (take_exc)
          begin
            vec_q      <= (frozen && !exc_is_trap) ? FATAL_VECTOR : exc_vector;
            vec_data_q <= exc_is_data && !(frozen && !exc_is_trap);
            if (exc_is_data && !(frozen && !exc_is_trap))
              state_q <= ST_SAVE;
            else
              state_q <= ST_DRAIN;
          end
        ST_DRAIN:
          if (!data_pending || data_fault)
            state_q <= ST_SAVE;
        ST_SAVE:   state_q <= ST_SWITCH;
        ST_SWITCH: state_q <= ST_VECTOR;
        ST_VECTOR: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status and saved status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      status_q <= STATUS_RESET;
      saved_q  <= STATUS_RESET;
    end
    else
    begin
      if (state_q == ST_SAVE && !frozen)
        saved_q <= status_q;
      else if (wr_req && wr_addr == OFS_SAVED)
        saved_q <= merge(saved_q, wr_data, wmask) | STATUS_ONE_MASK;
      if (state_q == ST_SWITCH)
        status_q <= status_q | ENTRY_SET_MASK;
      else if (rte_exec && state_q == ST_IDLE)
        status_q <= saved_q;
      else if (wr_req && wr_addr == OFS_STATUS)
        status_q <= merge(status_q, wr_data, wmask) | STATUS_ONE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Scoreboard and shadow scoreboard
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sb_q        <= '0;
      shadow_sb_q <= '0;
    end
    else
    begin
      if (state_q == ST_SWITCH)
        sb_q <= '0;
      else
        sb_q <= (sb_q | sb_set) & ~sb_clr;
      if (!frozen && state_q != ST_SWITCH)
        shadow_sb_q <= ((shadow_sb_q | sb_set) & ~sb_clr) & ~SB_W'(1);
      else if (wr_req && wr_addr == OFS_SHADOW_SB)
        shadow_sb_q <= SB_W'(merge(32'(shadow_sb_q), wr_data, wmask)) & ~SB_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sh_exec_q   <= 32'h0000_0000;
      sh_next_q   <= 32'h0000_0000;
      sh_fetch_q  <= 32'h0000_0000;
      fetch_ptr_q <= 32'h0000_0000;
      vbase_q     <= 32'h0000_0000;
    end
    else
    begin
      if (!frozen && state_q != ST_SWITCH)
      begin
        sh_exec_q  <= cur_exec_ptr;
        sh_next_q  <= cur_next_ptr;
        sh_fetch_q <= cur_fetch_ptr;
      end
      else if (wr_req && wr_addr == OFS_SH_EXEC)
        sh_exec_q <= merge(sh_exec_q, wr_data, wmask);
      else if (wr_req && wr_addr == OFS_SH_NEXT)
        sh_next_q <= merge(sh_next_q, wr_data, wmask);
      else if (wr_req && wr_addr == OFS_SH_FETCH)
        sh_fetch_q <= merge(sh_fetch_q, wr_data, wmask);
      if (state_q == ST_SWITCH)
        fetch_ptr_q <= {vbase_q[31:12], vec_q, 3'b000};
      if (wr_req && wr_addr == OFS_VBASE)
        vbase_q <= merge(vbase_q, wr_data, wmask) & VBASE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Data transaction registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      xact_stat_q  <= 32'h0000_0000;
      fault_addr_q <= 32'h0000_0000;
      fault_val_q  <= 32'h0000_0000;
    end
    else if (data_fault && (state_q == ST_DRAIN || (take_exc && vec_data_ok(exc_is_data))))
    begin
      xact_stat_q[XACT_VALID_BIT] <= 1'b1;
      fault_addr_q <= data_fault_addr;
      if (data_fault_store)
        fault_val_q <= data_fault_value;
    end
    else if (wr_req && wr_addr == OFS_XACT_STAT)
      xact_stat_q <= merge(xact_stat_q, wr_data, wmask);
    else if (wr_req && wr_addr == OFS_FAULT_ADDR)
      fault_addr_q <= merge(fault_addr_q, wr_data, wmask);
    else if (wr_req && wr_addr == OFS_FAULT_VAL)
      fault_val_q <= merge(fault_val_q, wr_data, wmask);
  end

  function automatic logic vec_data_ok(input logic d);
    vec_data_ok = d;
  endfunction : vec_data_ok

  // Float control and status change only by software
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      float_ctrl_q <= 32'h0000_0000;
      float_stat_q <= 32'h0000_0000;
    end
    else if (wr_req && wr_addr == OFS_FLOAT_CTRL)
      float_ctrl_q <= merge(float_ctrl_q, wr_data, wmask);
    else if (wr_req && wr_addr == OFS_FLOAT_STAT)
      float_stat_q <= merge(float_stat_q, wr_data, wmask);
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      exc_busy         <= 1'b0;
      fetch_redirect   <= 1'b0;
      fetch_addr       <= 32'h0000_0000;
      ptr_valid_clear  <= 1'b0;
      prefetch_discard <= 1'b0;
      code_fault_taken <= 1'b0;
      fp_wb_en         <= 1'b0;
      fp_exc_sig       <= 1'b0;
      scoreboard_out   <= '0;
      status_out       <= STATUS_RESET;
    end
    else
    begin
      exc_busy         <= (state_q != ST_IDLE) || take_exc;
      fetch_redirect   <= (state_q == ST_VECTOR);
      fetch_addr       <= fetch_ptr_q;
      ptr_valid_clear  <= (state_q == ST_VECTOR);
      prefetch_discard <= (state_q != ST_IDLE) && prefetch_resp;
      code_fault_taken <= (state_q == ST_IDLE) && prefetch_fault;
      fp_wb_en         <= fp_wb_req && !status_q[FLOAT_DISABLE_BIT];
      fp_exc_sig       <= fp_exc_req && !status_q[FLOAT_DISABLE_BIT];
      scoreboard_out   <= sb_q;
      status_out       <= status_q;
    end
  end

endmodule : exception_recognition_sequencer

`default_nettype wire

// ===== verification/exc_seq_props.sv
// Checker: entry state, drain, gating of the exception sequencer.
// Assumes binding into every exception_recognition_sequencer.
`default_nettype none

module exc_seq_props
  import exc_seq_pkg::*;
#(
  parameter int SB_W = 32
)
(
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire logic            exc_busy,
  input wire logic            exc_is_data,
  input wire logic            data_pending,
  input wire logic            fetch_redirect,
  input wire logic [31:0]     fetch_addr,
  input wire logic            ptr_valid_clear,
  input wire logic [31:0]     status_out,
  input wire logic [SB_W-1:0] scoreboard_out,
  input wire logic            fp_wb_en,
  input wire logic            fp_exc_sig,
  input wire logic            fp_wb_req,
  input wire logic            prefetch_resp,
  input wire logic            prefetch_discard,
  input wire logic            prefetch_fault,
  input wire logic            code_fault_taken
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_entry;
    fetch_redirect |-> (status_out & ENTRY_SET_MASK) == ENTRY_SET_MASK;
  endproperty
  a_entry:
    assert property (p_entry) else $error("entry status bits missing");
  property p_sb_clear;
    fetch_redirect |-> scoreboard_out == '0;
  endproperty
  a_sb_clear:
    assert property (p_sb_clear) else $error("scoreboard not cleared");
  property p_vec;
    fetch_redirect |-> ptr_valid_clear && fetch_addr[2:0] == 3'b000;
  endproperty
  a_vec:
    assert property (p_vec) else $error("vector fetch malformed");
  property p_pulse;
    fetch_redirect |=> !fetch_redirect;
  endproperty
  a_pulse:
    assert property (p_pulse) else $error("redirect longer than one cycle");
  property p_fp_gate;
    status_out[3] && $past(status_out[3]) |-> !fp_wb_en && !fp_exc_sig;
  endproperty
  a_fp_gate:
    assert property (p_fp_gate) else $error("float unit active while disabled");
  property p_drain;
    exc_busy && data_pending && !exc_is_data |=> !fetch_redirect;
  endproperty
  a_drain:
    assert property (p_drain) else $error("redirect before drain");
  property p_keep;
    fetch_redirect |-> status_out[30:4] == $past(status_out[30:4]) && status_out[2] == $past(status_out[2]);
  endproperty
  a_keep:
    assert property (p_keep) else $error("other status bits changed");
  property p_discard;
    prefetch_resp && exc_busy && !fetch_redirect |=> prefetch_discard;
  endproperty
  a_discard:
    assert property (p_discard) else $error("stale prefetch kept");
  property p_code_fault;
    prefetch_fault && !fetch_redirect |=> code_fault_taken == !$past(exc_busy);
  endproperty
  a_code_fault:
    assert property (p_code_fault) else $error("code fault forwarding wrong");
  property p_fp_pass;
    fp_wb_req |=> fp_wb_en == !status_out[3];
  endproperty
  a_fp_pass:
    assert property (p_fp_pass) else $error("float write back wrongly gated");
endmodule : exc_seq_props

bind exception_recognition_sequencer exc_seq_props #(.SB_W(SB_W)) exc_seq_props_i (.ref_clk, .rstn,
  .exc_busy, .exc_is_data, .data_pending, .fetch_redirect, .fetch_addr, .ptr_valid_clear, .status_out,
  .scoreboard_out, .fp_wb_en, .fp_exc_sig, .prefetch_resp, .prefetch_discard, .fp_wb_req, .prefetch_fault,
  .code_fault_taken);

`default_nettype wire

// ===== verification/data_unit_model.sv
// Data unit stand-in: accesses outstanding for a count, optional fault.
// Assumes the bench loads the count with the exception request.
`default_nettype none

module data_unit_model
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        load,
  input  wire logic [4:0]  count,
  input  wire logic        fault_en,
  output logic             data_pending,
  output logic             data_fault,
  output logic [31:0]      data_fault_addr,
  output logic [31:0]      data_fault_value,
  output logic             data_fault_store
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] left_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      left_q <= 5'h00;
    else if (load)
      left_q <= count;
    else if (left_q != 5'h00)
      left_q <= left_q - 5'h01;
  end
  // Fault rides on the last access; payload meaningless otherwise
  assign data_pending     = left_q != 5'h00;
  assign data_fault       = fault_en && left_q == 5'h01;
  assign data_fault_addr  = data_fault ? 32'h0000_2468 : ~32'h0000_2468;
  assign data_fault_value = data_fault ? 32'h5a5a_1234 : ~32'h5a5a_1234;
  assign data_fault_store = data_fault;
endmodule : data_unit_model

`default_nettype wire

// ===== verification/tb.sv
// Bench: registers over AXI4-Lite, exception entry, fatal, return.
// Assumes the data unit model and the bound checker.
`default_nettype none

module tb;
  import exc_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] S0 = 32'h4000_03f4;
  logic        ref_clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
  logic        s_bvalid, s_arready, s_rvalid, exc_req, exc_is_data, rte_exec, pf, fp_req, load, fault_en, trap;
  logic        data_pending, data_fault, data_fault_store, exc_busy, fetch_redirect;
  logic [7:0]  s_awaddr, s_araddr;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [8:0]  exc_vector;
  logic [4:0]  count;
  logic [31:0] s_wdata, s_rdata, fetch_addr, sb_set, data_fault_addr, data_fault_value, rd, ptr;
  int          errors = 0, total_checks = 0, cyc = 0, n;

  exception_recognition_sequencer exception_recognition_sequencer_i (.ref_clk, .rstn, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .exc_req,
    .exc_vector, .exc_is_data, .exc_is_trap(trap), .rte_exec, .data_pending, .data_fault,
    .data_fault_addr, .data_fault_value, .data_fault_store, .sb_set, .sb_clr(32'h0), .cur_exec_ptr(ptr),
    .cur_next_ptr(ptr + 32'h4), .cur_fetch_ptr(ptr + 32'h8), .prefetch_resp(pf), .prefetch_fault(pf),
    .fp_wb_req(fp_req), .fp_exc_req(fp_req), .exc_busy, .fetch_redirect, .fetch_addr, .ptr_valid_clear(),
    .prefetch_discard(), .code_fault_taken(), .fp_wb_en(), .fp_exc_sig(), .scoreboard_out(), .status_out());
  data_unit_model data_unit_model_i (.ref_clk, .rstn, .load, .count, .fault_en, .data_pending,
    .data_fault, .data_fault_addr, .data_fault_value, .data_fault_store);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge ref_clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_arready) s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    chk(nm, e, rd & m);
  endtask : rdc
  task automatic run_exc(input logic [8:0] v, input logic dat, input logic [4:0] c, input logic [31:0] e);
    @(posedge ref_clk);
    exc_req     <= 1'b1;
    exc_vector  <= v;
    exc_is_data <= dat;
    load        <= 1'b1;
    count       <= c;
    fault_en    <= 1'b1;
    fp_req      <= 1'b1;
    pf          <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    exc_req <= 1'b0;
    load    <= 1'b0;
    while (!fetch_redirect)
    begin
      @(posedge ref_clk);
      n++;
    end
    pf <= 1'b0;
    chk("vector address", e, fetch_addr);
  endtask : run_exc
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, exc_req, exc_is_data, rte_exec} = '0;
    {pf, fp_req, load, fault_en, trap, s_awaddr, s_araddr, s_wdata, exc_vector, count, sb_set} = '0;
    ptr = 32'h0000_1000;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(OFS_STATUS, '1, STATUS_RESET, "status reset");
    rdc(8'h3c, '1, 32'h0, "unmapped data");
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
    wr(OFS_SCORE, 32'hffff_ffff);
    chk("read-only resp", 32'(RESP_SLVERR), 32'(rsp));
    $display("registers done");
    wr(OFS_STATUS, S0);
    wr(OFS_VBASE, 32'h1234_5000);
    wr(OFS_FLOAT_CTRL, 32'h0000_00aa);
    wr(OFS_XACT_STAT, 32'h0);
    sb_set <= 32'h0000_00f0;
    @(posedge ref_clk);
    sb_set <= 32'h0;
    run_exc(9'h005, 1'b0, 5'd6, 32'h1234_5028);
    chk("drain wait", 32'h1, 32'(n > 6));
    rdc(OFS_STATUS, '1, S0 | ENTRY_SET_MASK, "entry status");
    rdc(OFS_SAVED, '1, S0, "saved status");
    rdc(OFS_SCORE, '1, 32'h0, "scoreboard");
    rdc(OFS_SHADOW_SB, '1, 32'h0000_00f0, "shadow scoreboard");
    rdc(OFS_SH_NEXT, 32'hffff_fffc, 32'h0000_1004, "shadow next");
    rdc(OFS_XACT_STAT, 32'h1, 32'h1, "drain fault valid");
    rdc(OFS_FAULT_ADDR, '1, 32'h0000_2468, "fault address");
    rdc(OFS_FAULT_VAL, '1, 32'h5a5a_1234, "fault value");
    rdc(OFS_FLOAT_CTRL, '1, 32'h0000_00aa, "float control");
    $display("entry done");
    run_exc(9'h005, 1'b0, 5'd0, 32'h1234_5050);
    trap <= 1'b1;
    run_exc(9'h080, 1'b0, 5'd0, 32'h1234_5400);
    trap <= 1'b0;
    rdc(OFS_SAVED, '1, S0, "saved while frozen");
    @(posedge ref_clk);
    rte_exec <= 1'b1;
    @(posedge ref_clk);
    rte_exec <= 1'b0;
    rdc(OFS_STATUS, '1, S0, "status after return");
    $display("fatal and return done");
    wr(OFS_XACT_STAT, 32'h0);
    run_exc(9'h003, 1'b0 | 1'b1, 5'd20, 32'h1234_5018);
    chk("data exception skips drain", 32'h1, 32'(n < 6));
    exc_is_data <= 1'b0;
    fault_en    <= 1'b0;
    rdc(OFS_XACT_STAT, 32'h1, 32'h0, "no fault valid");
    $display("data exception done");
    summarize();
  end
endmodule : tb

`default_nettype wire
